// >>> rtl/csd_clock_ctrl.sv
`timescale 1ns/10ps
// clock source select and divider control; all clocks are one-cycle ticks
module csd_clock_ctrl (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [2:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        fll_tick,
  input  wire logic        pll_tick,
  input  wire logic        int_ref_tick,
  input  wire logic        ext_ref_tick,
  input  wire logic        pll_select,
  input  wire logic        stop_req,
  input  wire logic        lock_lost_evt,
  output logic             sys_clk_tick,
  output logic             ref_div_tick,
  output logic             int_ref_clock_out,
  output logic             ext_ref_clock_out,
  output logic             debug_clock_out,
  output logic             loop_enable,
  output logic             int_ref_run,
  output logic             ext_ref_run,
  output logic             osc_range_high,
  output logic             osc_high_gain,
  output logic             ext_source_osc_sel,
  output logic      [8:0]  int_ref_trim,
  output csd_pkg::csd_mode_t op_mode
);
  import csd_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    logic [7:0] trim;
    logic       ftrim;
    logic       lock_lost;
    logic [1:0] cur_src;
    logic [1:0] stat_s1;
    logic [1:0] stat_s2;
    logic       iref_s1;
    logic       iref_s2;
    csd_mode_t  mode;
    csd_mode_t  pre_stop;
    logic       dbg_half;
    logic       dbg_out;
    logic [7:0] rdata;
    logic       iref_out;
    logic       eref_out;
    logic       loop_en;
    logic       iref_run;
    logic       eref_run;
  } csd_st_t;

  csd_st_t st_ff;
  csd_st_t nxt_st;

  logic       bus_at_start;
  logic       sys_src_tick;
  logic       ref_tick;
  logic [1:0] eff_src;
  logic [2:0] ref_divider_code;
  logic [2:0] bus_divider_code;
  logic       wr_ctrl1;
  logic       wr_ctrl2;
  logic       wr_status;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [1:0] fold_src(input logic [1:0] s);
    return (s == SRC_RSVD) ? SRC_LOOP : s;
  endfunction : fold_src

  function automatic logic is_bypass(input csd_mode_t m);
    return (m == FLOOP_BYPASSED_INT) || (m == FLOOP_BYPASSED_EXT) ||
           (m == PLOOP_BYPASSED_EXT) || (m == LOWPOWER_BYPASS_INT) ||
           (m == LOWPOWER_BYPASS_EXT);
  endfunction : is_bypass

  function automatic logic uses_int(input csd_mode_t m);
    return (m == FLOOP_ENGAGED_INT) || (m == FLOOP_BYPASSED_INT) ||
           (m == LOWPOWER_BYPASS_INT);
  endfunction : uses_int

  function automatic logic uses_ext(input csd_mode_t m);
    return (m == FLOOP_ENGAGED_EXT) || (m == FLOOP_BYPASSED_EXT) ||
           (m == PLOOP_ENGAGED_EXT) || (m == PLOOP_BYPASSED_EXT) ||
           (m == LOWPOWER_BYPASS_EXT);
  endfunction : uses_ext

  // nine modes decoded from source, reference, loop choice and low power
  function automatic csd_mode_t decode_mode(input logic [1:0] src, input logic iref,
                                            input logic pll, input logic lp,
                                            input logic stop);
    csd_mode_t m;
    m = FLOOP_ENGAGED_INT;
    if (stop) begin
      m = MODE_STOP;
    end else if (src == SRC_LOOP) begin
      m = pll ? PLOOP_ENGAGED_EXT : (iref ? FLOOP_ENGAGED_INT : FLOOP_ENGAGED_EXT);
    end else if (src == SRC_INT) begin
      m = lp ? LOWPOWER_BYPASS_INT : FLOOP_BYPASSED_INT;
    end else begin
      m = lp ? LOWPOWER_BYPASS_EXT : (pll ? PLOOP_BYPASSED_EXT : FLOOP_BYPASSED_EXT);
    end
    return m; // R15
  endfunction : decode_mode

  // ----------------------------------------------------------------
  // decode and source muxes
  // ----------------------------------------------------------------
  assign eff_src   = fold_src(st_ff.ctrl1[C1_SRC_LO +: 2]); // R02
  assign ref_divider_code = st_ff.ctrl1[C1_REF_DIVIDER_LO +: 3];
  assign bus_divider_code = {1'b0, st_ff.ctrl2[C2_BUS_DIVIDER_LO +: 2]};
  assign wr_ctrl1  = reg_wr && (reg_addr == ADDR_CTRL1);
  assign wr_ctrl2  = reg_wr && (reg_addr == ADDR_CTRL2);
  assign wr_status = reg_wr && (reg_addr == ADDR_STATUS);

  // reference for the loop; only counted while that reference is running
  assign ref_tick = st_ff.ctrl1[C1_IREF_SEL] ? (int_ref_tick && st_ff.iref_run)
                                             : (ext_ref_tick && st_ff.eref_run); // R05

  // active source tick; the source field switches at a bus divider boundary, pll_select at once
  always_comb begin
    unique case (st_ff.cur_src)
      SRC_INT:  sys_src_tick = int_ref_tick; // R01
      SRC_EXT:  sys_src_tick = ext_ref_tick;
      default:  sys_src_tick = pll_select ? pll_tick : fll_tick;
    endcase
  end

  // ----------------------------------------------------------------
  // dividers
  // ----------------------------------------------------------------
  csd_pow2_div u_ref_div (
    .mclk     (mclk),
    .rst      (rst),
    .tick_in  (ref_tick),
    .code     (ref_divider_code),
    .tick_out (ref_div_tick),
    .at_start ()
  );

  csd_pow2_div u_bus_div (
    .mclk     (mclk),
    .rst      (rst),
    .tick_in  (sys_src_tick),
    .code     (bus_divider_code),
    .tick_out (sys_clk_tick),
    .at_start (bus_at_start)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st       = st_ff;
    nxt_st.rdata = 8'h00;

    // software writes
    if (wr_ctrl1) begin
      nxt_st.ctrl1 = reg_wdata;
    end
    if (wr_ctrl2) begin
      nxt_st.ctrl2 = reg_wdata; // R09 R10 R12
    end
    if (reg_wr && (reg_addr == ADDR_TRIM)) begin
      nxt_st.trim = reg_wdata; // R17
    end
    if (reg_wr && (reg_addr == ADDR_FTRIM)) begin
      nxt_st.ftrim = reg_wdata[0];
    end

    // sticky loss of lock: a new event wins over a same-cycle clear
    if (wr_status && reg_wdata[ST_LOCKLOST] && st_ff.lock_lost) begin
      nxt_st.lock_lost = 1'b0; // R20
    end
    if (lock_lost_evt) begin
      nxt_st.lock_lost = 1'b1; // R20
    end

    // switching only at a period boundary keeps the bus tick free of runts
    if (bus_at_start) begin
      nxt_st.cur_src = eff_src; // R21 R01
    end

    // status lags the switch by two stages
    nxt_st.stat_s1 = ((st_ff.cur_src == SRC_LOOP) && pll_select) ? STAT_PLL : st_ff.cur_src;
    nxt_st.stat_s2 = st_ff.stat_s1; // R19
    nxt_st.iref_s1 = st_ff.ctrl1[C1_IREF_SEL];
    nxt_st.iref_s2 = st_ff.iref_s1;

    // operating mode and the mode held before stop
    nxt_st.mode = decode_mode(st_ff.cur_src, st_ff.ctrl1[C1_IREF_SEL], pll_select,
                              st_ff.ctrl2[C2_LP], stop_req);
    if (st_ff.mode != MODE_STOP) begin
      nxt_st.pre_stop = st_ff.mode;
    end

    // loop is off in stop, and in bypass when low power is asked for
    nxt_st.loop_en = !stop_req &&
                     !(is_bypass(st_ff.mode) && st_ff.ctrl2[C2_LP]); // R11

    // reference enables; in stop only the stop enable can hold them on
    if (stop_req) begin
      nxt_st.iref_run = st_ff.ctrl1[C1_IREF_STP] &&
                        (st_ff.ctrl1[C1_IREF_OEN] || uses_int(st_ff.pre_stop)); // R07
      nxt_st.eref_run = st_ff.ctrl2[C2_EREF_STP] &&
                        (st_ff.ctrl2[C2_EREF_OEN] || uses_ext(st_ff.pre_stop)); // R14
    end else begin
      nxt_st.iref_run = st_ff.ctrl1[C1_IREF_OEN] || st_ff.ctrl1[C1_IREF_SEL] ||
                        (eff_src == SRC_INT) || uses_int(st_ff.mode);
      nxt_st.eref_run = st_ff.ctrl2[C2_EREF_OEN] || !st_ff.ctrl1[C1_IREF_SEL] ||
                        (eff_src == SRC_EXT) || uses_ext(st_ff.mode);
    end

    // gated reference outputs
    nxt_st.iref_out = int_ref_tick && st_ff.ctrl1[C1_IREF_OEN] && st_ff.iref_run; // R06
    nxt_st.eref_out = ext_ref_tick && st_ff.ctrl2[C2_EREF_OEN] && st_ff.eref_run; // R13

    // debug clock: every second oscillator core tick, in either loop mode
    nxt_st.dbg_out = 1'b0;
    if (fll_tick) begin
      nxt_st.dbg_half = !st_ff.dbg_half;
      nxt_st.dbg_out  = st_ff.dbg_half; // R16
    end

    // read data stands one cycle after the strobe; unmapped reads zero
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_CTRL1:  nxt_st.rdata = st_ff.ctrl1;
        ADDR_CTRL2:  nxt_st.rdata = st_ff.ctrl2;
        ADDR_STATUS: nxt_st.rdata = {st_ff.lock_lost, 2'b00, st_ff.iref_s2,
                                     st_ff.stat_s2, 2'b00};
        ADDR_TRIM:   nxt_st.rdata = st_ff.trim;
        ADDR_FTRIM:  nxt_st.rdata = {7'h00, st_ff.ftrim};
        default:     nxt_st.rdata = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_ff          <= '0;
      st_ff.ctrl1    <= CTRL1_RST; // R03
      st_ff.ctrl2    <= CTRL2_RST; // R08
      st_ff.trim     <= TRIM_RST;
      st_ff.mode     <= FLOOP_ENGAGED_INT;
      st_ff.pre_stop <= FLOOP_ENGAGED_INT;
      st_ff.iref_run <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all internal to the chip
  // ----------------------------------------------------------------
  assign reg_rdata          = st_ff.rdata;
  assign int_ref_clock_out  = st_ff.iref_out; // R18
  assign ext_ref_clock_out  = st_ff.eref_out;
  assign debug_clock_out    = st_ff.dbg_out;
  assign loop_enable        = st_ff.loop_en;
  assign int_ref_run        = st_ff.iref_run;
  assign ext_ref_run        = st_ff.eref_run;
  assign osc_range_high     = st_ff.ctrl2[C2_RANGE]; // R09
  assign osc_high_gain      = st_ff.ctrl2[C2_GAIN]; // R10
  assign ext_source_osc_sel = st_ff.ctrl2[C2_OSC_SEL]; // R12
  assign int_ref_trim       = {st_ff.trim, st_ff.ftrim}; // R17
  assign op_mode            = st_ff.mode;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_switch_seen;
    $changed(st_ff.cur_src) && (st_ff.cur_src != SRC_LOOP);
  endsequence

  sequence s_status_follows;
    ##2 (st_ff.stat_s2 == $past(st_ff.cur_src, 2));
  endsequence

  AST_SRC_ONLY_AT_BOUNDARY: assert property ( // R21
    $changed(st_ff.cur_src) |-> $past(bus_at_start))
    else $error("source changed away from a period boundary");

  AST_RSVD_IS_LOOP: assert property ( // R02
    (st_ff.ctrl1[C1_SRC_LO +: 2] == SRC_RSVD) && bus_at_start |=> st_ff.cur_src == SRC_LOOP)
    else $error("reserved source code did not select the loop");

  AST_STATUS_LAGS: assert property ( // R19
    s_switch_seen |-> s_status_follows)
    else $error("mode status did not follow the source two cycles later");

  AST_LOCK_SET: assert property ( // R20
    lock_lost_evt |=> st_ff.lock_lost)
    else $error("loss of lock event not held");

  AST_LOCK_CLEAR: assert property ( // R20
    wr_status && reg_wdata[ST_LOCKLOST] && !lock_lost_evt |=> !st_ff.lock_lost)
    else $error("write one did not clear loss of lock");

  AST_LOCK_ZERO_KEEPS: assert property ( // R20
    st_ff.lock_lost && !(wr_status && reg_wdata[ST_LOCKLOST]) |=> st_ff.lock_lost)
    else $error("loss of lock cleared without a write of one");

  AST_IREF_GATE: assert property ( // R06
    !st_ff.ctrl1[C1_IREF_OEN] |=> !int_ref_clock_out)
    else $error("internal reference output active while disabled");

  AST_EREF_GATE: assert property ( // R13
    !st_ff.ctrl2[C2_EREF_OEN] |=> !ext_ref_clock_out)
    else $error("external reference output active while disabled");

  AST_LP_BYPASS: assert property ( // R11
    is_bypass(st_ff.mode) && st_ff.ctrl2[C2_LP] |=> !loop_enable)
    else $error("loop left running in a low power bypass mode");

  AST_STOP_IREF: assert property ( // R07
    stop_req && !st_ff.ctrl1[C1_IREF_STP] |=> !int_ref_run)
    else $error("internal reference kept in stop without stop enable");

  AST_STOP_EREF: assert property ( // R14
    stop_req && !st_ff.ctrl2[C2_EREF_STP] |=> !ext_ref_run)
    else $error("external reference kept in stop without stop enable");

  AST_DBG_HALF: assert property ( // R16
    fll_tick && st_ff.dbg_half |=> debug_clock_out ##0 !st_ff.dbg_half)
    else $error("debug clock is not half the core rate");

endmodule : csd_clock_ctrl

// >>> rtl/csd_pkg.sv
// Summary of operation
// R01 - source field picks loop, internal, external
// R02 - reserved source code acts as loop
// R03 - reference divided by 1 to 128
// R04 - software keeps divided reference in range
// R05 - reference select bit picks internal reference
// R06 - internal reference output gated by enable
// R07 - internal reference kept in stop conditionally
// R08 - bus divider 1,2,4,8, resets to 2
// R09 - range bit sets oscillator frequency band
// R10 - gain bit sets high gain or low power
// R11 - low power bit stops loop when bypassed
// R12 - source bit requests crystal or clock input
// R13 - external reference output gated by enable
// R14 - external reference kept in stop conditionally
// R15 - nine operating modes including stop
// R16 - debug clock is oscillator core halved
// R17 - internal reference has nine trim bits
// R18 - no signal leaves the chip
// R19 - mode status follows source after sync delay
// R20 - lock lost flag sticky, write one clears
// R21 - source and divider changes free of runts
package csd_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [2:0] ADDR_CTRL1  = 3'h0;
  localparam logic [2:0] ADDR_CTRL2  = 3'h1;
  localparam logic [2:0] ADDR_STATUS = 3'h2;
  localparam logic [2:0] ADDR_TRIM   = 3'h3;
  localparam logic [2:0] ADDR_FTRIM  = 3'h4;

  localparam logic [7:0] CTRL1_RST = 8'h04;
  localparam logic [7:0] CTRL2_RST = 8'h40;
  localparam logic [7:0] TRIM_RST  = 8'h80;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int C1_SRC_LO   = 6;
  localparam int C1_REF_DIVIDER_LO  = 3;
  localparam int C1_IREF_SEL = 2;
  localparam int C1_IREF_OEN = 1;
  localparam int C1_IREF_STP = 0;
  localparam int C2_BUS_DIVIDER_LO  = 6;
  localparam int C2_RANGE    = 5;
  localparam int C2_GAIN     = 4;
  localparam int C2_LP       = 3;
  localparam int C2_OSC_SEL  = 2;
  localparam int C2_EREF_OEN = 1;
  localparam int C2_EREF_STP = 0;
  localparam int ST_LOCKLOST = 7;
  localparam int ST_IREF_ST  = 4;
  localparam int ST_MODE_LO  = 2;

  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] SRC_LOOP = 2'h0;
  localparam logic [1:0] SRC_INT  = 2'h1;
  localparam logic [1:0] SRC_EXT  = 2'h2;
  localparam logic [1:0] SRC_RSVD = 2'h3;
  localparam logic [1:0] STAT_PLL = 2'h3;

  typedef enum logic [3:0] {
    FLOOP_ENGAGED_INT,
    FLOOP_ENGAGED_EXT,
    FLOOP_BYPASSED_INT,
    FLOOP_BYPASSED_EXT,
    PLOOP_ENGAGED_EXT,
    PLOOP_BYPASSED_EXT,
    LOWPOWER_BYPASS_INT,
    LOWPOWER_BYPASS_EXT,
    MODE_STOP
  } csd_mode_t;

endpackage : csd_pkg

// >>> rtl/csd_pow2_div.sv
`timescale 1ns/10ps
// power-of-two tick divider; a new code is taken only at a count boundary
module csd_pow2_div (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       tick_in,
  input  wire logic [2:0] code,
  output logic            tick_out,
  output logic            at_start
);
  import csd_pkg::*;

  typedef struct packed {
    logic [6:0] cnt;
    logic [2:0] code;
    logic       pulse;
  } csd_div_st_t;

  csd_div_st_t st_ff;
  csd_div_st_t nxt_st;

  function automatic logic [6:0] last_count(input logic [2:0] c);
    logic [7:0] full;
    full = (8'h01 << c) - 8'h01;
    return full[6:0];
  endfunction : last_count

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  // latching the code only at the boundary avoids a runt output period
  always_comb begin
    nxt_st       = st_ff;
    nxt_st.pulse = 1'b0;
    if (st_ff.cnt == 7'h00) begin
      nxt_st.code = code; // R21
    end
    if (tick_in) begin
      if (st_ff.cnt >= last_count((st_ff.cnt == 7'h00) ? code : st_ff.code)) begin
        nxt_st.cnt   = 7'h00;
        nxt_st.pulse = 1'b1; // R03 R08
      end else begin
        nxt_st.cnt = st_ff.cnt + 7'h01;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tick_out = st_ff.pulse;
  assign at_start = (st_ff.cnt == 7'h00);

endmodule : csd_pow2_div

// >>> testbench/csd_osc_model.sv
`timescale 1ns/10ps
// tick source model: both loops and both references as one-cycle enables
module csd_osc_model (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic slow,
  input  wire logic loop_enable,
  input  wire logic int_ref_run,
  input  wire logic ext_ref_run,
  output logic      fll_tick,
  output logic      pll_tick,
  output logic      int_ref_tick,
  output logic      ext_ref_tick
);
  localparam logic [4:0] PER [4] = '{5'h01, 5'h02, 5'h04, 5'h06};

  logic [4:0] cnt [4];
  logic [3:0] run;

  // ----------------------------------------------------------------
  // free counters; a stopped source stands still, no stray ticks
  // ----------------------------------------------------------------
  // everything stays on chip, no pad models here
  assign run = {ext_ref_run, int_ref_run, loop_enable, loop_enable};

  // slow roughly doubles every period to stress the dividers
  always_ff @(posedge mclk) begin
    for (int i = 0; i < 4; i++) begin
      if (rst || cnt[i] >= (slow ? {PER[i][3:0], 1'b1} : PER[i]))
        cnt[i] <= '0;
      else
        cnt[i] <= cnt[i] + 5'h01;
    end
  end

  // no lock tracking, so divided reference range is not judged
  assign fll_tick     = run[0] && cnt[0] == '0;
  assign pll_tick     = run[1] && cnt[1] == '0;
  assign int_ref_tick = run[2] && cnt[2] == '0;
  assign ext_ref_tick = run[3] && cnt[3] == '0;
endmodule : csd_osc_model

// >>> testbench/clock_source_select_divider_tb.sv
`timescale 1ns/10ps
module clock_source_select_divider_tb;
  import csd_pkg::*;

  // mode table: c1, c2, {pll, stop, int run, ext run}, loop enable, mode
  localparam logic [31:0] CASES [14] = '{
    32'h0440_0100, 32'h4440_0102, 32'h4448_0006, 32'h0040_0101, 32'h8040_0103,
    32'h0040_8104, 32'h8040_8105, 32'h8048_0007, 32'h0540_6008, 32'h0440_4008,
    32'h0041_5008, 32'h0140_4008, 32'h0443_5008, 32'h0340_6008};

  logic        mclk, rst, reg_wr, reg_rd, pll_select, stop_req, lock_lost_evt, slow;
  logic [2:0]  reg_addr, ua;
  logic [7:0]  reg_wdata, reg_rdata, v;
  logic        fll_tick, pll_tick, int_ref_tick, ext_ref_tick, sys_clk_tick, ref_div_tick;
  logic        int_ref_clock_out, ext_ref_clock_out, debug_clock_out, loop_enable;
  logic        int_ref_run, ext_ref_run, osc_range_high, osc_high_gain, ext_source_osc_sel;
  logic [8:0]  int_ref_trim, tk;
  csd_mode_t   op_mode;
  logic [31:0] seed, cs;
  logic [1:0]  sr;
  int          cnt [9] = '{default: 0};
  int          base [9];
  int          d [9];
  int          num_errors, cmp_count;

  csd_clock_ctrl u_csd_clock_ctrl (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .fll_tick(fll_tick), .pll_tick(pll_tick), .int_ref_tick(int_ref_tick),
    .ext_ref_tick(ext_ref_tick), .pll_select(pll_select), .stop_req(stop_req),
    .lock_lost_evt(lock_lost_evt), .sys_clk_tick(sys_clk_tick), .ref_div_tick(ref_div_tick),
    .int_ref_clock_out(int_ref_clock_out), .ext_ref_clock_out(ext_ref_clock_out),
    .debug_clock_out(debug_clock_out), .loop_enable(loop_enable), .int_ref_run(int_ref_run),
    .ext_ref_run(ext_ref_run), .osc_range_high(osc_range_high), .osc_high_gain(osc_high_gain),
    .ext_source_osc_sel(ext_source_osc_sel), .int_ref_trim(int_ref_trim), .op_mode(op_mode));

  csd_osc_model u_csd_osc_model (.mclk(mclk), .rst(rst), .slow(slow),
    .loop_enable(loop_enable), .int_ref_run(int_ref_run), .ext_ref_run(ext_ref_run),
    .fll_tick(fll_tick), .pll_tick(pll_tick), .int_ref_tick(int_ref_tick),
    .ext_ref_tick(ext_ref_tick));

  // ----------------------------------------------------------------
  // clock, tick counters, helpers
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  assign tk = {debug_clock_out, ext_ref_clock_out, int_ref_clock_out, ref_div_tick,
               sys_clk_tick, ext_ref_tick, int_ref_tick, pll_tick, fll_tick};
  // running totals; windows take differences so no clear is needed
  always @(posedge mclk) foreach (cnt[i]) cnt[i] <= cnt[i] + int'(tk[i]);

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs

  // status code expected for a source field and loop choice
  function automatic logic [1:0] exp_stat(input logic [1:0] src, input logic pll);
    if (src == SRC_INT || src == SRC_EXT)
      return src;
    return pll ? STAT_PLL : SRC_LOOP;
  endfunction : exp_stat

  // which counted tick feeds the bus divider
  function automatic int src_idx(input logic [1:0] src, input logic pll);
    if (src == SRC_INT)
      return 2;
    if (src == SRC_EXT)
      return 3;
    return pll ? 1 : 0;
  endfunction : src_idx

  // tolerance covers window edges cutting a divider period
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp,
                     input int tol = 0);
    cmp_count++;
    // an unknown never slips through the tolerance branch
    if (seen !== exp && (tol <= 0 || $isunknown(seen) || seen + tol < exp ||
                         seen > exp + tol)) begin
      num_errors++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [7:0] dv);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= dv;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr

  // data stand only in the cycle after the strobe edge
  task automatic rd(input logic [2:0] a);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd

  task automatic cfg(input logic [7:0] c1, input logic [7:0] c2, input logic pll, input int n);
    wr(ADDR_CTRL1, c1);
    wr(ADDR_CTRL2, c2);
    pll_select <= pll;
    repeat (n) @(posedge mclk);
    #1;
  endtask : cfg

  task automatic win(input int n);
    @(posedge mclk);
    #1 base = cnt;
    repeat (n) @(posedge mclk);
    #1 foreach (d[i]) d[i] = cnt[i] - base[i];
  endtask : win

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude

  // ----------------------------------------------------------------
  // watchdog, sized well above the ~55k cycles of the sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (90000) @(posedge mclk);
    num_errors++;
    conclude();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {reg_wr, reg_rd, pll_select, stop_req, lock_lost_evt, slow} = '0;
    reg_addr   = '0;
    reg_wdata  = '0;
    num_errors = 0;
    cmp_count  = 0;
    seed       = 32'h8b7c7fc8;
    rst        = 1'b1;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    rd(ADDR_CTRL1);
    chk("ref_divider rst", v[5:3], 3'h0);
    chk("ctrl1 rst", v, CTRL1_RST);
    rd(ADDR_CTRL2);
    chk("bus_divider rst", v[7:6], 2'h1);
    rd(ADDR_STATUS);
    chk("lock rst", v[ST_LOCKLOST], 1'b0);
    chk("stat rst", v[3:2], SRC_LOOP);
    chk("mode rst", op_mode, FLOOP_ENGAGED_INT);
    // random register traffic, unmapped index among it
    for (int i = 0; i < 16; i++) begin
      seed = xs(seed);
      ua   = 3'h5 + 3'(seed[25:24] % 2'h3);
      wr(ADDR_CTRL1, seed[7:0]);
      wr(ADDR_CTRL2, seed[15:8]);
      wr(ADDR_TRIM, seed[23:16]);
      wr(ua, seed[31:24]);
      wr(ADDR_FTRIM, seed[31:24]);
      rd(ADDR_FTRIM);
      chk("ftrim rd", v, {7'h00, seed[24]});
      chk("ftrim", int_ref_trim[0], seed[24]);
      rd(ADDR_CTRL1);
      chk("ctrl1", v, seed[7:0]);
      rd(ADDR_CTRL2);
      chk("ctrl2", v, seed[15:8]);
      rd(ua);
      chk("unmapped", v, 8'h00);
      chk("range", osc_range_high, seed[13]);
      chk("gain", osc_high_gain, seed[12]);
      chk("osc sel", ext_source_osc_sel, seed[10]);
      chk("trim", int_ref_trim[8:1], seed[23:16]);
    end
    // sticky loss flag: zero write keeps it, one write clears it
    @(posedge mclk);
    lock_lost_evt <= 1'b1;
    @(posedge mclk);
    lock_lost_evt <= 1'b0;
    rd(ADDR_STATUS);
    chk("lock set", v[ST_LOCKLOST], 1'b1);
    wr(ADDR_STATUS, 8'h00);
    rd(ADDR_STATUS);
    chk("lock kept", v[ST_LOCKLOST], 1'b1);
    wr(ADDR_STATUS, 8'h80);
    rd(ADDR_STATUS);
    chk("lock clr", v[ST_LOCKLOST], 1'b0);
    // every mode, then stop retention from FLOOP_ENGAGED_INT and FLOOP_ENGAGED_EXT
    for (int i = 0; i < 14; i++) begin
      cs = CASES[i];
      @(posedge mclk);
      stop_req <= 1'b0;
      cfg(cs[31:24], cs[23:16], cs[15], 150);
      if (cs[14]) begin
        @(posedge mclk);
        stop_req <= 1'b1;
        repeat (4) @(posedge mclk);
        #1;
        chk("int run", int_ref_run, cs[13]);
        chk("ext run", ext_ref_run, cs[12]);
      end else begin
        chk("loop en", loop_enable, cs[8]);
        rd(ADDR_STATUS);
        chk("mode stat", v[3:2], exp_stat(cs[31:30], cs[15]));
        chk("ref stat", v[ST_IREF_ST], cs[26]);
      end
      chk("mode", op_mode, cs[3:0]);
    end
    @(posedge mclk);
    stop_req <= 1'b0;
    // every source code, every bus divisor, gated outputs, random rate
    for (int b = 0; b < 4; b++) begin
      for (int s = 0; s < 5; s++) begin
        seed = xs(seed);
        slow <= seed[0];
        sr = (s == 4) ? SRC_LOOP : 2'(s);
        cfg({sr, 4'b0001, b[0], 1'b0}, {2'(b), 4'h0, b[1], 1'b0}, s == 4, 300);
        win(600);
        chk("sys div", d[4], d[src_idx(sr, s == 4)] >> b, 1);
        chk("int out", d[6], b[0] ? d[2] : 0, b & 1);
        chk("ext out", d[7], b[1] ? d[3] : 0, b >> 1);
        chk("debug", d[8], d[0] / 2, 1);
      end
    end
    // every reference divisor, reference select alternating
    slow <= 1'b0;
    for (int r = 0; r < 8; r++) begin
      cfg({SRC_LOOP, 3'(r), r[0], 2'b00}, CTRL2_RST, 1'b0, 1000);
      win(3000);
      chk("ref div", d[5], d[r[0] ? 2 : 3] >> r, 1);
    end
    conclude();
  end
endmodule : clock_source_select_divider_tb
